//--- rtl/prie_pkg.sv
// Constants for the power, reset and interrupt-enable register bank
package prie_pkg;
    // Register access port widths
    localparam int unsigned REG_W  = 24;
    localparam int unsigned ADDR_W = 8;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_GEN_CFG  = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_CHN_CTRL = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PWR      = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_ADC_CMD  = 8'h20;

    // Interrupt-enable field positions
    localparam int unsigned IRQ_N       = 5;
    localparam int unsigned IRQ_THERMAL = 4;
    localparam int unsigned IRQ_OVC     = 3;
    localparam int unsigned IRQ_CFG     = 2;
    localparam int unsigned IRQ_LINK    = 1;
    localparam int unsigned IRQ_EDGE    = 0;
    localparam logic [IRQ_N-1:0] IRQ_EN_RST = 5'h00;

    // Power-control field positions
    localparam int unsigned PWR_DAC_PD  = 23;
    localparam int unsigned PWR_DAC_RST = 21;
    localparam int unsigned PWR_GPD     = 19;
    localparam int unsigned PWR_GSR     = 17;

    // ADC command fields and codes
    localparam int unsigned ADC_MODE_LSB = 20;
    localparam int unsigned ADC_MODE_W   = 2;
    localparam int unsigned ADC_RATE_LSB = 16;
    localparam int unsigned ADC_RATE_W   = 4;
    localparam logic [ADC_MODE_W-1:0] MODE_PD   = 2'h1;
    localparam logic [ADC_MODE_W-1:0] MODE_CONV = 2'h3;
    localparam logic [ADC_RATE_W-1:0] RATE_RST  = 4'h0;

    // Configuration register reset values and bits kept by soft reset
    localparam logic [REG_W-1:0] GLOBAL_SOFT_RESET_VAL   = 24'h00_0000;
    localparam logic [REG_W-1:0] CHN_RST_VAL   = 24'h00_0000;
    localparam logic [REG_W-1:0] GEN_KEEP_MASK = 24'h00_0007;
    localparam logic [REG_W-1:0] ZERO_WORD     = 24'h00_0000;
endpackage

//--- rtl/prie_cfg_if.sv
// Carrier between the register bank and the configuration shadow
`timescale 1ns/100ps
`default_nettype none
interface prie_cfg_if;
    import prie_pkg::*;
    logic             wr_gen;
    logic             wr_chn;
    logic [REG_W-1:0] wdata;
    logic             gpd;
    logic             gsr;
    logic [REG_W-1:0] gen_q;
    logic [REG_W-1:0] chn_q;
    logic [REG_W-1:0] gen_act;
    logic [REG_W-1:0] chn_act;

    // Bank side drives strobes and controls
    modport bank (output wr_gen, wr_chn, wdata, gpd, gsr,
                  input gen_q, chn_q, gen_act, chn_act);
    // Shadow side holds stored and applied copies
    modport shadow (input wr_gen, wr_chn, wdata, gpd, gsr,
                    output gen_q, chn_q, gen_act, chn_act);
endinterface
`default_nettype wire

//--- rtl/prie_cfg_shadow.sv
// Stored and applied copies of general config and channel control
`timescale 1ns/100ps
`default_nettype none
module prie_cfg_shadow (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Bank connection
    prie_cfg_if.shadow cfg
);
    import prie_pkg::*;

    logic [REG_W-1:0] gen_d, chn_d, gen_act_d, chn_act_d;
    logic [REG_W-1:0] gen_q, chn_q, gen_act_q, chn_act_q;

    // Next values of stored and applied copies
    always_comb begin
        gen_d = gen_q;
        chn_d = chn_q;
        if (cfg.gsr) begin
            gen_d = (gen_q & GEN_KEEP_MASK) | (GLOBAL_SOFT_RESET_VAL & ~GEN_KEEP_MASK); // RULE_08
            chn_d = CHN_RST_VAL; // RULE_08
        end else begin
            if (cfg.wr_gen) begin
                gen_d = cfg.wdata; // RULE_07
            end
            if (cfg.wr_chn) begin
                chn_d = cfg.wdata; // RULE_07
            end
        end
        // Applied copy frozen during global power-down
        gen_act_d = cfg.gpd ? gen_act_q : gen_q; // RULE_07
        chn_act_d = cfg.gpd ? chn_act_q : chn_q; // RULE_06
    end

    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_q     <= GLOBAL_SOFT_RESET_VAL;
            chn_q     <= CHN_RST_VAL;
            gen_act_q <= GLOBAL_SOFT_RESET_VAL;
            chn_act_q <= CHN_RST_VAL;
        end else begin
            gen_q     <= gen_d;
            chn_q     <= chn_d;
            gen_act_q <= gen_act_d;
            chn_act_q <= chn_act_d;
        end
    end

    assign cfg.gen_q   = gen_q;
    assign cfg.chn_q   = chn_q;
    assign cfg.gen_act = gen_act_q;
    assign cfg.chn_act = chn_act_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Applied settings hold during power-down
    chk_apply_hold_pd: assert property (cfg.gpd |=> $stable(chn_act_q) && $stable(gen_act_q)) // RULE_07
        else $error("applied config changed during global power-down");
    // Applied channel control tracks the stored one once power-down is clear
    chk_apply_restore: assert property (!cfg.gpd |=> chn_act_q == $past(chn_q)) // RULE_06
        else $error("applied channel control did not follow stored value");
    // Soft reset clears channel control despite writes
    chk_gsr_clears: assert property (cfg.gsr |=> chn_q == CHN_RST_VAL) // RULE_11
        else $error("channel control not held at reset value during soft reset");
    // Kept fields survive soft reset
    chk_gsr_keeps: assert property (cfg.gsr |=>
            (gen_q & GEN_KEEP_MASK) == ($past(gen_q) & GEN_KEEP_MASK)) // RULE_08
        else $error("kept config fields changed during soft reset");
endmodule
`default_nettype wire

//--- rtl/prie_regs.sv
// Power-control, ADC command and interrupt-enable register bank
// How it works
// RULE_01 - Interrupt enables reset to 0; a 0 blocks its event from the interrupt pin.
// RULE_02 - Thermal enable at bit 4, overcurrent at bit 3, config error at bit 2.
// RULE_03 - Link checksum enable at bit 1, input edge enable at bit 0.
// RULE_04 - DAC soft reset is writable bit 21, resets to 0, resets DAC output logic.
// RULE_05 - Global power-down bit 19 powers down all amplifiers; resets to 0.
// RULE_06 - Clearing global power-down restores state from current config registers.
// RULE_07 - Config writes accepted during power-down, applied only after it clears.
// RULE_08 - Soft reset bit 17 resets config registers except kept reference/checksum fields.
// RULE_09 - Setting soft reset immediately aborts any running ADC conversion.
// RULE_10 - Soft reset bit never self-clears; host must write 0 to leave reset.
// RULE_11 - While soft reset is 1, config register writes are ignored.
// RULE_12 - ADC mode 01 is power-down (reset), 11 conversion; 00 and 10 reserved.
// RULE_13 - While converting, mode writes ignored unless they request power-down.
// RULE_14 - DAC power-down bit 23 resets to 0; writing 1 powers the DAC down.
// RULE_15 - Reserved bits read as zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
module prie_regs #(
    parameter int unsigned DATA_W = prie_pkg::REG_W
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Register access port
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [prie_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]            reg_wdata,
    output logic      [DATA_W-1:0]            reg_rdata,
    // Interrupt events and pin
    input  wire logic [prie_pkg::IRQ_N-1:0]   irq_events,
    output logic                              irq_n,
    // ADC control
    input  wire logic                         adc_busy,
    output logic                              adc_abort,
    output logic [prie_pkg::ADC_MODE_W-1:0]   adc_mode,
    output logic [prie_pkg::ADC_RATE_W-1:0]   adc_rate,
    // Power and reset controls
    output logic                              dac_power_down,
    output logic                              dac_soft_reset,
    output logic                              amp_power_down,
    output logic                              soft_reset_active,
    // Applied configuration
    output logic [DATA_W-1:0]                 gen_cfg_applied,
    output logic [DATA_W-1:0]                 chn_ctrl_applied
);
    import prie_pkg::*;

    // Width check
    if (DATA_W != REG_W) begin : g_bad_width
        $error("prie_regs: DATA_W must equal the register width");
    end

    prie_cfg_if cfg_bus ();

    prie_cfg_shadow u_shadow (
        .clk (clk),
        .rst (rst),
        .cfg (cfg_bus)
    );

    logic                  wr_irq, wr_pwr, wr_adc;
    logic [IRQ_N-1:0]      irq_en_d, irq_en_q;
    logic                  dac_pd_d, dac_pd_q, dac_rst_d, dac_rst_q;
    logic                  gpd_d, gpd_q, gsr_d, gsr_q;
    logic                  abort_d, abort_q, irq_n_d, irq_n_q;
    logic [ADC_MODE_W-1:0] mode_d, mode_q, mode_wr;
    logic [ADC_RATE_W-1:0] rate_d, rate_q;
    logic [REG_W-1:0]      rdata_d, rdata_q;

    // Write decode
    assign wr_irq = reg_wr && (reg_addr == ADDR_IRQ_EN);
    assign wr_pwr = reg_wr && (reg_addr == ADDR_PWR);
    assign wr_adc = reg_wr && (reg_addr == ADDR_ADC_CMD);
    assign mode_wr = reg_wdata[ADC_MODE_LSB +: ADC_MODE_W];

    // Config strobes, ignored while soft reset holds
    assign cfg_bus.wr_gen = reg_wr && (reg_addr == ADDR_GEN_CFG) && !gsr_q; // RULE_11
    assign cfg_bus.wr_chn = reg_wr && (reg_addr == ADDR_CHN_CTRL) && !gsr_q; // RULE_11
    assign cfg_bus.wdata  = reg_wdata;
    assign cfg_bus.gpd    = gpd_q;
    assign cfg_bus.gsr    = gsr_q;

    // Next values of control registers
    always_comb begin
        irq_en_d  = irq_en_q;
        dac_pd_d  = dac_pd_q;
        dac_rst_d = dac_rst_q;
        gpd_d     = gpd_q;
        gsr_d     = gsr_q;
        mode_d    = mode_q;
        rate_d    = rate_q;
        if (wr_irq) begin
            irq_en_d[IRQ_THERMAL] = reg_wdata[IRQ_THERMAL]; // RULE_02
            irq_en_d[IRQ_OVC]     = reg_wdata[IRQ_OVC]; // RULE_02
            irq_en_d[IRQ_CFG]     = reg_wdata[IRQ_CFG]; // RULE_02
            irq_en_d[IRQ_LINK]    = reg_wdata[IRQ_LINK]; // RULE_03
            irq_en_d[IRQ_EDGE]    = reg_wdata[IRQ_EDGE]; // RULE_03
        end
        if (wr_pwr) begin
            dac_pd_d  = reg_wdata[PWR_DAC_PD]; // RULE_14
            dac_rst_d = reg_wdata[PWR_DAC_RST]; // RULE_04
            gpd_d     = reg_wdata[PWR_GPD]; // RULE_05
            gsr_d     = reg_wdata[PWR_GSR]; // RULE_10
        end
        if (wr_adc) begin
            rate_d = reg_wdata[ADC_RATE_LSB +: ADC_RATE_W];
            // Reserved codes dropped; running conversion only leaves by power-down
            case (mode_wr)
                MODE_PD: mode_d = MODE_PD; // RULE_13
                MODE_CONV: begin
                    if (!adc_busy) begin
                        mode_d = MODE_CONV; // RULE_13
                    end
                end
                default: mode_d = mode_q; // RULE_12
            endcase
        end
        // Abort on rising soft reset
        abort_d = gsr_d && !gsr_q; // RULE_09
        // Enabled events drive the low-active pin
        irq_n_d = ~|(irq_events & irq_en_q); // RULE_01
    end

    // Control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_en_q  <= IRQ_EN_RST; // RULE_01
            dac_pd_q  <= 1'b0;
            dac_rst_q <= 1'b0;
            gpd_q     <= 1'b0;
            gsr_q     <= 1'b0;
            mode_q    <= MODE_PD;
            rate_q    <= RATE_RST;
            abort_q   <= 1'b0;
            irq_n_q   <= 1'b1;
        end else begin
            irq_en_q  <= irq_en_d;
            dac_pd_q  <= dac_pd_d;
            dac_rst_q <= dac_rst_d;
            gpd_q     <= gpd_d;
            gsr_q     <= gsr_d;
            mode_q    <= mode_d;
            rate_q    <= rate_d;
            abort_q   <= abort_d;
            irq_n_q   <= irq_n_d;
        end
    end

    // Read data; unmapped and reserved bits read zero, held between reads
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            rdata_d = ZERO_WORD; // RULE_15
            case (reg_addr)
                ADDR_GEN_CFG:  rdata_d = cfg_bus.gen_q;
                ADDR_CHN_CTRL: rdata_d = cfg_bus.chn_q;
                ADDR_IRQ_EN:   rdata_d[IRQ_N-1:0] = irq_en_q;
                ADDR_PWR: begin
                    rdata_d[PWR_DAC_PD]  = dac_pd_q;
                    rdata_d[PWR_DAC_RST] = dac_rst_q;
                    rdata_d[PWR_GPD]     = gpd_q;
                    rdata_d[PWR_GSR]     = gsr_q;
                end
                ADDR_ADC_CMD: begin
                    rdata_d[ADC_MODE_LSB +: ADC_MODE_W] = mode_q;
                    rdata_d[ADC_RATE_LSB +: ADC_RATE_W] = rate_q;
                end
                default: rdata_d = ZERO_WORD;
            endcase
        end
    end

    // Read data register, held until next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= ZERO_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign reg_rdata         = rdata_q;
    assign irq_n             = irq_n_q;
    assign adc_abort         = abort_q;
    assign adc_mode          = mode_q;
    assign adc_rate          = rate_q;
    assign dac_power_down    = dac_pd_q;
    assign dac_soft_reset    = dac_rst_q;
    assign amp_power_down    = gpd_q; // RULE_05
    assign soft_reset_active = gsr_q;
    assign gen_cfg_applied   = cfg_bus.gen_act;
    assign chn_ctrl_applied  = cfg_bus.chn_act;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Disabled sources never pull the pin low
    chk_irq_masked: assert property ((irq_events & irq_en_q) == 5'h00 |=> irq_n) // RULE_01
        else $error("interrupt pin asserted by a disabled source");
    // Enable bits land at their positions
    chk_irq_en_bits: assert property (wr_irq |=> irq_en_q == $past(reg_wdata[IRQ_N-1:0])) // RULE_02
        else $error("interrupt enable bits not stored at their positions");
    // DAC reset and power-down follow their bits
    chk_dac_bits: assert property (wr_pwr |=> dac_soft_reset == $past(reg_wdata[PWR_DAC_RST])
            && dac_power_down == $past(reg_wdata[PWR_DAC_PD])) // RULE_04
        else $error("DAC control bits not taken from bits 21 and 23");
    // Global power-down drives amplifiers off
    chk_gpd_amp: assert property (wr_pwr && reg_wdata[PWR_GPD] |=> amp_power_down) // RULE_05
        else $error("amplifiers not powered down after bit 19 set");
    // Abort in the cycle soft reset rises
    chk_gsr_abort: assert property ($rose(gsr_q) |-> adc_abort ##1 !adc_abort) // RULE_09
        else $error("conversion abort not a single pulse at soft reset");
    // Soft reset stays until written
    chk_gsr_sticky: assert property (gsr_q && !wr_pwr |=> gsr_q) // RULE_10
        else $error("soft reset bit cleared without a write");
    // Mode stays legal
    chk_mode_legal: assert property (adc_mode == MODE_PD || adc_mode == MODE_CONV) // RULE_12
        else $error("ADC mode holds a reserved code");
    // Busy ADC ignores non power-down mode writes
    chk_mode_busy: assert property (wr_adc && adc_busy && mode_wr != MODE_PD
            |=> $stable(adc_mode)) // RULE_13
        else $error("ADC mode changed during conversion");
    // Reserved power-control bits read zero
    chk_pwr_resv: assert property (reg_rd && reg_addr == ADDR_PWR
            |=> (reg_rdata & 24'h55_FFFF) == 24'h00_0000) // RULE_15
        else $error("reserved power-control bits read nonzero");
endmodule
`default_nettype wire

//--- dv/prie_host_model.sv
// Host model driving the register access port one word at a time
`timescale 1ns/100ps
`default_nettype none
module prie_host_model (
    // Clock
    input  wire logic                       clk,
    // Register access port
    output logic                            reg_wr,
    output logic                            reg_rd,
    output logic [prie_pkg::ADDR_W-1:0]     reg_addr,
    output logic [prie_pkg::REG_W-1:0]      reg_wdata,
    input  wire logic [prie_pkg::REG_W-1:0] reg_rdata
);
    import prie_pkg::*;
    // Idle port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h00_0000;
    end
    // Whole-word write; stale address and data inverted once released
    task automatic write(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask
    // Whole-word read; data taken once the registered answer has landed
    task automatic read(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
        #1;
    endtask
endmodule
`default_nettype wire

//--- dv/power_reset_irq_enable_regs_bench.sv
// Self-checking bench for the power, reset and interrupt-enable bank
`timescale 1ns/100ps
`default_nettype none
module power_reset_irq_enable_regs_bench;
    import prie_pkg::*;
    logic clk, rst, reg_wr, reg_rd, irq_n, adc_busy, adc_abort;
    logic dac_power_down, dac_soft_reset, amp_power_down, soft_reset_active;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0]  reg_wdata, reg_rdata, gen_cfg_applied, chn_ctrl_applied;
    logic [IRQ_N-1:0]  irq_events;
    logic [1:0]        adc_mode;
    logic [3:0]        adc_rate;
    int                errors, num_checks;

    // Design and host
    prie_regs u_prie_regs (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_events(irq_events), .irq_n(irq_n),
        .adc_busy(adc_busy), .adc_abort(adc_abort), .adc_mode(adc_mode), .adc_rate(adc_rate),
        .dac_power_down(dac_power_down), .dac_soft_reset(dac_soft_reset),
        .amp_power_down(amp_power_down), .soft_reset_active(soft_reset_active),
        .gen_cfg_applied(gen_cfg_applied), .chn_ctrl_applied(chn_ctrl_applied)
    );
    prie_host_model u_prie_host_model (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare, count and report
    task automatic cmp(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        u_prie_host_model.write(a, d);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e, input string m);
        logic [REG_W-1:0] v;
        u_prie_host_model.read(a, v);
        cmp(v, e, m);
    endtask
    task automatic wait_edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reset values with every event raised
    task automatic t_reset;
        rdc(ADDR_IRQ_EN, 24'h00_0000, "irq enable reset");
        rdc(ADDR_PWR, 24'h00_0000, "power reset");
        rdc(ADDR_ADC_CMD, 24'h10_0000, "adc cmd reset");
        cmp(REG_W'(irq_n), 24'h00_0001, "pin idle");
        $display("test reset done");
    endtask

    // Each enable gates only its own event
    task automatic t_irq;
        wr(ADDR_IRQ_EN, 24'hFF_FFFF);
        rdc(ADDR_IRQ_EN, 24'h00_001F, "irq reserved");
        for (int i = 0; i < IRQ_N; i++) begin
            wr(ADDR_IRQ_EN, REG_W'(1) << i);
            @(posedge clk);
            irq_events <= ~(5'h01 << i);
            wait_edges(2);
            cmp(REG_W'(irq_n), 24'h00_0001, "others blocked");
            @(posedge clk);
            irq_events <= 5'h01 << i;
            wait_edges(2);
            cmp(REG_W'(irq_n), 24'h00_0000, "own event");
        end
        wr(ADDR_IRQ_EN, 24'h00_0000);
        wait_edges(2);
        cmp(REG_W'(irq_n), 24'h00_0001, "disabled again");
        $display("test irq done");
    endtask

    // Power bits, reserved bits read zero
    task automatic t_power;
        wr(ADDR_PWR, 24'hFF_FFFF);
        cmp(REG_W'({dac_power_down, dac_soft_reset, amp_power_down, soft_reset_active}),
            24'h00_000F, "power outputs");
        rdc(ADDR_PWR, 24'hAA_0000, "power reserved");
        wr(ADDR_PWR, 24'h00_0000);
        cmp(REG_W'({dac_power_down, dac_soft_reset, amp_power_down}), 24'h0, "power off");
        $display("test power done");
    endtask

    // Config deferred across global power-down
    task automatic t_defer;
        wr(ADDR_CHN_CTRL, 24'h00_5A5A);
        wait_edges(2);
        cmp(chn_ctrl_applied, 24'h00_5A5A, "applied");
        wr(ADDR_PWR, 24'h08_0000);
        wr(ADDR_CHN_CTRL, 24'h12_3456);
        wait_edges(4);
        cmp(chn_ctrl_applied, 24'h00_5A5A, "frozen");
        cmp(REG_W'(amp_power_down), 24'h00_0001, "amps down");
        rdc(ADDR_CHN_CTRL, 24'h12_3456, "stored in pd");
        wr(ADDR_PWR, 24'h00_0000);
        wait_edges(2);
        cmp(chn_ctrl_applied, 24'h12_3456, "restored");
        $display("test defer done");
    endtask

    // Soft reset aborts, clears config, blocks writes, holds
    task automatic t_soft;
        wr(ADDR_GEN_CFG, 24'hAB_CDEF);
        @(posedge clk);
        adc_busy <= 1'b1;
        wr(ADDR_PWR, 24'h02_0000);
        cmp(REG_W'(adc_abort), 24'h00_0001, "abort");
        wait_edges(1);
        cmp(REG_W'(adc_abort), 24'h00_0000, "abort once");
        @(posedge clk);
        adc_busy <= 1'b0;
        rdc(ADDR_GEN_CFG, 24'h00_0007, "kept fields");
        cmp(gen_cfg_applied, 24'h00_0007, "gen applied reset");
        rdc(ADDR_CHN_CTRL, 24'h00_0000, "chan cleared");
        wr(ADDR_GEN_CFG, 24'h11_1110);
        rdc(ADDR_GEN_CFG, 24'h00_0007, "write ignored");
        rdc(ADDR_PWR, 24'h02_0000, "no self clear");
        wr(ADDR_PWR, 24'h00_0000);
        wr(ADDR_GEN_CFG, 24'h11_1110);
        rdc(ADDR_GEN_CFG, 24'h11_1110, "write after");
        cmp(gen_cfg_applied, 24'h11_1110, "gen applied");
        $display("test soft reset done");
    endtask

    // Mode codes, busy filter, unmapped address
    task automatic t_adc;
        wr(ADDR_ADC_CMD, 24'hF5_FFFF);
        rdc(ADDR_ADC_CMD, 24'h35_0000, "cmd reserved");
        cmp(REG_W'({adc_mode, adc_rate}), 24'h00_0035, "mode rate out");
        wr(ADDR_ADC_CMD, 24'h02_0000);
        rdc(ADDR_ADC_CMD, 24'h32_0000, "code 00");
        wr(ADDR_ADC_CMD, 24'h23_0000);
        rdc(ADDR_ADC_CMD, 24'h33_0000, "code 10");
        @(posedge clk);
        adc_busy <= 1'b1;
        wr(ADDR_ADC_CMD, 24'h14_0000);
        rdc(ADDR_ADC_CMD, 24'h14_0000, "pd while busy");
        wr(ADDR_ADC_CMD, 24'h36_0000);
        rdc(ADDR_ADC_CMD, 24'h16_0000, "conv while busy");
        @(posedge clk);
        adc_busy <= 1'b0;
        wr(8'h3F, 24'hFF_FFFF);
        rdc(8'h3F, 24'h00_0000, "unmapped");
        $display("test adc done");
    endtask

    // Verdict
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        rst = 1'b1;
        adc_busy = 1'b0;
        irq_events = 5'h1F;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_irq;
        t_power;
        t_defer;
        t_soft;
        t_adc;
        final_report;
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        $display("mismatch at %0t: watchdog", $time);
        final_report;
    end
endmodule
`default_nettype wire
